// ===== shared/sec_pkg.sv
package sec_pkg;
  localparam int DQ_W = 68;
  localparam int CMD_W = 10;
  localparam logic [1:0] CMD_READ = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_SEARCH = 2'h2;
  localparam logic [1:0] CMD_LEARN = 2'h3;
  localparam int CMD_BURST_BIT = 2;
  localparam int CMD_UPPER_HI = 8;
  localparam int CMD_UPPER_LO = 7;
  localparam int TAG_HI = 25;
  localparam int TAG_LO = 21;
  localparam logic [4:0] TAG_ALL = 5'h1F;
  localparam int SPACE_HI = 20;
  localparam int SPACE_LO = 19;
  localparam logic [1:0] SPACE_DATA = 2'h0;
  localparam logic [1:0] SPACE_MASK = 2'h1;
  localparam logic [1:0] SPACE_SRAM = 2'h2;
  localparam logic [1:0] SPACE_REG = 2'h3;
  localparam int ADDR_W = 15;
  localparam int SETUP_ADR_LO = 0;
  localparam int SETUP_CNT_LO = 19;
  localparam int CNT_W = 9;
  localparam int REG_ADDR_W = 6;
  localparam logic [ADDR_W-1:0] SETUP_ADR_RST = 15'h0000;
  localparam logic [CNT_W-1:0] SETUP_CNT_RST = 9'h000;
  localparam int COMPARANDS = 16;
  localparam int FIFO_DEPTH = 16;
  typedef enum logic [1:0] {SEC_W68, SEC_W136, SEC_W272} sec_width_t;
endpackage

// ===== rtl/sec_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module sec_fifo #(
  parameter int WIDTH = 68,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_ff;
  logic [AW:0] rd_ff;
  logic [AW:0] cnt;
  logic push;
  logic pop;
  ////////////////////////////////////////
  // honest full and empty from pointer difference
  assign cnt = wr_ff - rd_ff;
  assign in_ready = (cnt != (AW+1)'(DEPTH));
  assign out_valid = (cnt != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // first-word-fall-through read
  assign out_data = mem_ff[rd_ff[AW-1:0]];
  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ff[AW-1:0]] <= in_data;
    end
  end
  // pointers
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= rd_ff + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/sec_mem.sv
`timescale 1ns/1ns
`default_nettype none
module sec_mem #(
  parameter int WIDTH = 68,
  parameter int AW = 8
) (
  // clock
  input wire logic clk,
  // write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // registered read port
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem_ff [2**AW];
  // single write port, no reset so it maps to ram
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_ff[wr_addr] <= wr_data;
    end
  end
  // read data comes out of a register
  always_ff @(posedge clk) begin
    if (rd_en) begin
      rd_data <= mem_ff[rd_addr];
    end
  end
endmodule
`default_nettype wire

// ===== rtl/sec_read_port.sv
`timescale 1ns/1ns
`default_nettype none
module sec_read_port
  #(
  parameter int ENTRIES_AW = 8,
  parameter logic [4:0] CASCADE_TAG = 5'h01 // arbitrary default
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // command bus
  input wire logic command_qualifier,
  input wire logic phase_marker,
  input wire logic [sec_pkg::CMD_W-1:0] cmd,
  // shared data bus, split
  input wire logic [sec_pkg::DQ_W-1:0] dq_in,
  output logic [sec_pkg::DQ_W-1:0] dq_out,
  output logic dq_oe,
  // response strobe and burst end flag
  output logic ack_out,
  output logic ack_oe,
  output logic burst_end_flag_out,
  output logic burst_end_flag_oe,
  // external memory upper address
  output logic [1:0] external_memory_upper_bits,
  // cascade and configuration
  input wire logic last_in_chain_flag,
  input wire logic [4:0] cascade_tag,
  input wire sec_pkg::sec_width_t width_cfg,
  // burst setup register load
  input wire logic setup_load,
  input wire logic [sec_pkg::DQ_W-1:0] setup_data,
  // array write port and search
  input wire logic arr_wr,
  input wire logic arr_wr_mask,
  input wire logic [ENTRIES_AW-1:0] arr_addr,
  input wire logic [sec_pkg::DQ_W-1:0] arr_data,
  input wire logic [sec_pkg::DQ_W-1:0] search_key,
  input wire logic [sec_pkg::DQ_W-1:0] global_mask,
  input wire logic [ENTRIES_AW-1:0] search_addr,
  output logic search_hit,
  // learn
  input wire logic [3:0] comparand_idx,
  input wire logic comparand_load,
  input wire logic [ENTRIES_AW-1:0] next_free_pointer,
  output logic learn_refused,
  // status
  output logic busy,
  output logic [sec_pkg::CNT_W-1:0] burst_count,
  output logic [sec_pkg::ADDR_W-1:0] read_burst_pointer
);
  import sec_pkg::*;
  typedef enum {ST_IDLE, ST_CYCB, ST_C2, ST_C3, ST_LOW, ST_HIGH, ST_END} sec_state_t;
  ////////////////////////////////////////
  sec_state_t st_ff;
  logic [1:0] code_a_ff;
  logic burst_ff;
  logic sel_ff;
  logic [1:0] space_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [REG_ADDR_W-1:0] reg_addr_ff;
  logic [DQ_W-1:0] comparand_ff [COMPARANDS];
  logic [DQ_W-1:0] data_rd;
  logic [DQ_W-1:0] mask_rd;
  logic [DQ_W-1:0] bit_match;
  logic rd_en;
  logic [ENTRIES_AW-1:0] rd_addr;
  logic fifo_valid;
  logic fifo_ready;
  logic [DQ_W-1:0] fifo_data;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [DQ_W-1:0] fifo_in_data;
  logic sel_now;
  logic learn_cmd;
  logic learn_wr;
  ////////////////////////////////////////
  // tag match, all-ones picks the chain end
  assign sel_now = (dq_in[TAG_HI:TAG_LO] == cascade_tag) ||
    ((dq_in[TAG_HI:TAG_LO] == TAG_ALL) && last_in_chain_flag);
  // learn decode; refused for 272-bit width
  assign learn_cmd = command_qualifier && (cmd[1:0] == CMD_LEARN) && (st_ff == ST_IDLE);
  assign learn_wr = learn_cmd && (width_cfg != SEC_W272);
  ////////////////////////////////////////
  // data and mask arrays; learn writes comparand at next free slot
  sec_mem #(.WIDTH(DQ_W), .AW(ENTRIES_AW)) u_data (
    .clk(clk),
    .wr_en((arr_wr && !arr_wr_mask) || learn_wr),
    .wr_addr(learn_wr ? next_free_pointer : arr_addr),
    .wr_data(learn_wr ? comparand_ff[cmd[5:2]] : arr_data),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(data_rd)
  );
  sec_mem #(.WIDTH(DQ_W), .AW(ENTRIES_AW)) u_mask (
    .clk(clk),
    .wr_en(arr_wr && arr_wr_mask),
    .wr_addr(arr_addr),
    .wr_data(arr_data),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(mask_rd)
  );
  // read port shared by readout and search; readout has priority
  assign rd_en = 1'b1;
  // the strobe-high cycle fetches the next location, so it is staged by the low cycle
  assign rd_addr = (st_ff == ST_C2) ? addr_ff[ENTRIES_AW-1:0] :
    (st_ff == ST_HIGH) ? addr_ff[ENTRIES_AW-1:0] + ENTRIES_AW'(1) : search_addr;
  // comparand store, sixteen entries
  always_ff @(posedge clk) begin
    if (comparand_load) begin
      comparand_ff[comparand_idx] <= search_key;
    end
  end
  ////////////////////////////////////////
  // per-bit ternary match with global then local mask
  genvar gi;
  generate
    for (gi = 0; gi < DQ_W; gi++) begin : g_bit
      assign bit_match[gi] = !global_mask[gi] || !mask_rd[gi] ||
        (data_rd[gi] == search_key[gi]);
    end
  endgenerate
  // hit only with every position matching
  always_ff @(posedge clk) begin
    if (reset) begin
      search_hit <= 1'b0;
    end else begin
      search_hit <= (&bit_match) && (st_ff == ST_IDLE);
    end
  end
  // learn refusal flag
  always_ff @(posedge clk) begin
    if (reset) begin
      learn_refused <= 1'b0;
    end else begin
      learn_refused <= learn_cmd && (width_cfg == SEC_W272);
    end
  end
  ////////////////////////////////////////
  // read word staging: array contents or the register address go into fifo; sram space stages zero
  assign fifo_in_valid = (st_ff == ST_C3 || st_ff == ST_LOW) && sel_ff;
  always_comb begin
    fifo_in_data = '0;
    case (space_ff)
      SPACE_DATA: fifo_in_data = data_rd;
      SPACE_MASK: fifo_in_data = mask_rd;
      SPACE_REG: fifo_in_data = {{(DQ_W-REG_ADDR_W){1'b0}}, reg_addr_ff};
      default: fifo_in_data = '0;
    endcase
  end
  sec_fifo #(.WIDTH(DQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_data)
  );
  // a word leaves on each strobe-high cycle
  assign fifo_ready = (st_ff == ST_HIGH) && sel_ff;
  ////////////////////////////////////////
  // sequencer; qualifier low means idle
  always_ff @(posedge clk) begin
    if (reset) begin
      st_ff <= ST_IDLE;
      code_a_ff <= 2'h0;
      burst_ff <= 1'b0;
      sel_ff <= 1'b0;
      space_ff <= SPACE_DATA;
      reg_addr_ff <= '0;
      addr_ff <= '0;
      external_memory_upper_bits <= 2'h0;
    end else begin
      case (st_ff)
        ST_IDLE: begin
          if (command_qualifier && cmd[1:0] == CMD_READ) begin
            st_ff <= ST_CYCB;
            code_a_ff <= cmd[CMD_UPPER_HI:CMD_UPPER_LO];
            burst_ff <= cmd[CMD_BURST_BIT];
          end
        end
        ST_CYCB: begin
          if (command_qualifier && cmd[1:0] == CMD_READ) begin
            st_ff <= ST_C2;
            sel_ff <= sel_now;
            space_ff <= dq_in[SPACE_HI:SPACE_LO];
            reg_addr_ff <= dq_in[REG_ADDR_W-1:0];
            addr_ff <= burst_ff ? read_burst_pointer : dq_in[ADDR_W-1:0];
            if (dq_in[SPACE_HI:SPACE_LO] == SPACE_SRAM) begin
              external_memory_upper_bits <= code_a_ff;
            end
          end else begin
            st_ff <= ST_IDLE;
          end
        end
        ST_C2: st_ff <= ST_C3;
        ST_C3: st_ff <= ST_HIGH; // cycle 4 drives low
        ST_LOW: st_ff <= ST_HIGH;
        ST_HIGH: begin
          // cycle 5; burst repeats the pair until count spent
          if (burst_ff && burst_count > 9'h001) begin
            st_ff <= ST_LOW;
            addr_ff <= addr_ff + 1'b1;
          end else begin
            st_ff <= ST_END;
          end
        end
        ST_END: st_ff <= ST_IDLE;
        default: st_ff <= ST_IDLE;
      endcase
    end
  end
  // burst setup register, pointer advances and count drops per access
  always_ff @(posedge clk) begin
    if (reset) begin
      read_burst_pointer <= SETUP_ADR_RST;
      burst_count <= SETUP_CNT_RST;
    end else if (setup_load) begin
      read_burst_pointer <= setup_data[SETUP_ADR_LO +: ADDR_W];
      burst_count <= setup_data[SETUP_CNT_LO +: CNT_W];
    end else if (st_ff == ST_HIGH && burst_ff && sel_ff && burst_count != '0) begin
      read_burst_pointer <= read_burst_pointer + 1'b1;
      burst_count <= burst_count - 1'b1;
    end
  end
  ////////////////////////////////////////
  // pin drive, registered; unselected device stays floating
  always_ff @(posedge clk) begin
    if (reset) begin
      dq_out <= '0;
      dq_oe <= 1'b0;
      ack_out <= 1'b0;
      ack_oe <= 1'b0;
      burst_end_flag_out <= 1'b0;
      burst_end_flag_oe <= 1'b0;
    end else begin
      dq_oe <= 1'b0;
      dq_out <= '0;
      ack_out <= 1'b0;
      ack_oe <= 1'b0;
      burst_end_flag_out <= 1'b0;
      burst_end_flag_oe <= 1'b0;
      if (sel_ff) begin
        case (st_ff)
          ST_C3, ST_LOW: begin
            dq_oe <= 1'b1;
            ack_oe <= 1'b1;
            burst_end_flag_oe <= burst_ff;
          end
          ST_HIGH: begin
            dq_oe <= 1'b1;
            dq_out <= fifo_data;
            ack_oe <= 1'b1;
            ack_out <= 1'b1;
            burst_end_flag_oe <= burst_ff;
            burst_end_flag_out <= burst_ff && burst_count <= 9'h001;
          end
          ST_END: begin
            ack_oe <= 1'b1;
            burst_end_flag_oe <= burst_ff;
          end
          default: begin
            dq_oe <= 1'b0;
          end
        endcase
      end
    end
  end
  // busy while a read runs
  always_ff @(posedge clk) begin
    if (reset) begin
      busy <= 1'b0;
    end else begin
      busy <= (st_ff != ST_IDLE) || !fifo_in_ready;
    end
  end
endmodule
`default_nettype wire

// ===== test/sec_read_port_properties.sv
`timescale 1ns/1ns
`default_nettype none
module sec_rp_props (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // command side
  input wire logic command_qualifier,
  input wire logic [sec_pkg::CMD_W-1:0] cmd,
  input wire logic [sec_pkg::DQ_W-1:0] dq_in,
  input wire logic last_in_chain_flag,
  input wire logic [4:0] cascade_tag,
  input wire sec_pkg::sec_width_t width_cfg,
  // answer side
  input wire logic dq_oe,
  input wire logic ack_out,
  input wire logic ack_oe,
  input wire logic burst_end_flag_out,
  input wire logic burst_end_flag_oe,
  input wire logic [1:0] external_memory_upper_bits,
  input wire logic learn_refused
);
  import sec_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // selection seen on the address cycle
  logic sel;
  assign sel = dq_in[TAG_HI:TAG_LO] == cascade_tag ||
    (dq_in[TAG_HI:TAG_LO] == TAG_ALL && last_in_chain_flag);
  // a quiet cycle first, so a B cycle is never mistaken for an A
  sequence rd_ab(logic b);
    !command_qualifier ##1 command_qualifier && cmd[1:0] == CMD_READ && cmd[2] == b
    ##1 command_qualifier && cmd[1:0] == CMD_READ && cmd[2] == b;
  endsequence
  property p_sram;
    logic [1:0] v;
    (!command_qualifier ##1 (command_qualifier && cmd[1:0] == CMD_READ, v = cmd[8:7])
    ##1 (command_qualifier && dq_in[SPACE_HI:SPACE_LO] == SPACE_SRAM && sel))
    |-> ##[1:5] external_memory_upper_bits == v;
  endproperty
  ////////////////////////////////////////////////////////////////
  a_single_walk: assert property (
    rd_ab(1'b0) ##0 sel |-> ##3 dq_oe && ack_oe && !ack_out ##1 dq_oe && ack_out
    ##1 !dq_oe && ack_oe && !ack_out ##1 !ack_oe && !dq_oe) else $error("single walk");
  a_burst_open: assert property (
    rd_ab(1'b1) ##0 sel |-> ##3 dq_oe && ack_oe && burst_end_flag_oe && !ack_out
    && !burst_end_flag_out) else $error("burst open");
  a_unsel_quiet: assert property (
    rd_ab(1'b0) ##0 !sel |-> ##1 (!dq_oe && !ack_oe && !burst_end_flag_oe)[*7])
    else $error("unselected drove");
  a_strobe_pulse: assert property (
    ack_out |=> !ack_out) else $error("strobe too long");
  a_drive_owns_ack: assert property (
    dq_oe |-> ack_oe) else $error("data without strobe");
  a_end_on_high: assert property (
    burst_end_flag_out |-> ack_out && dq_oe && burst_end_flag_oe) else $error("end flag");
  a_end_close: assert property (
    burst_end_flag_out |=> !dq_oe && ack_oe && !ack_out && burst_end_flag_oe
    && !burst_end_flag_out ##1 !ack_oe && !burst_end_flag_oe) else $error("burst close");
  a_sram_upper: assert property (p_sram) else $error("upper bits");
  a_learn_refuse: assert property (
    !command_qualifier ##1 command_qualifier && cmd[1:0] == CMD_LEARN
    && width_cfg == SEC_W272 |-> ##[1:4] learn_refused) else $error("learn not refused");
  c_burst: cover property (rd_ab(1'b1) ##0 sel);
  c_end: cover property (burst_end_flag_out);
  c_refuse: cover property (learn_refused);
endmodule
`default_nettype wire

// ===== test/sec_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module sec_host_model (
  // clock
  input wire logic clk,
  // device side of the data bus
  input wire logic [sec_pkg::DQ_W-1:0] dq_out,
  input wire logic dq_oe,
  output logic [sec_pkg::DQ_W-1:0] dq_in,
  // command bus
  output logic command_qualifier,
  output logic phase_marker,
  output logic [sec_pkg::CMD_W-1:0] cmd
);
  import sec_pkg::*;
  logic host_drv = 1'b0;
  logic [DQ_W-1:0] host_val = 68'h0;
  logic [DQ_W-1:0] last_ff = 68'h0;
  // floated bus flips every cycle so a stale value never reads as data
  always @(posedge clk) last_ff <= dq_in;
  assign dq_in = dq_oe ? dq_out : host_drv ? host_val : ~last_ff;
  initial begin
    command_qualifier = 1'b0;
    phase_marker = 1'b0;
    cmd = 10'h000;
  end
  // instruction in two cycles, A then B, changed on falling edges
  task automatic issue(input logic [CMD_W-1:0] c, input logic [DQ_W-1:0] a);
    @(negedge clk);
    command_qualifier = 1'b1;
    phase_marker = 1'b1;
    cmd = c;
    host_drv = 1'b1;
    host_val = a;
    @(negedge clk);
    phase_marker = 1'b0;
    cmd = {3'h0, c[6:0]};
    @(negedge clk);
    command_qualifier = 1'b0;
    cmd = 10'h000;
    host_drv = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import sec_pkg::*;
  localparam logic [DQ_W-1:0] BASE = 68'h9_1234_5678_9ABC_D000;
  localparam logic [DQ_W-1:0] MSK = ~68'h20;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic lic = 1'b0;
  logic sl = 1'b0;
  logic aw = 1'b0;
  logic awm = 1'b0;
  logic cl = 1'b0;
  logic seen;
  logic [4:0] tag = 5'h05;
  sec_width_t wc = SEC_W68;
  logic [DQ_W-1:0] sd = 68'h0, ad = 68'h0, key = 68'h0, gm = ~68'h0;
  logic [DQ_W-1:0] flip [4] = '{68'h0, 68'h20, 68'h40, 68'h40};
  logic [DQ_W-1:0] gclr [4] = '{68'h0, 68'h0, 68'h0, 68'h40};
  logic [3:0] hv = 4'hB;
  logic [7:0] aa = 8'h00;
  logic q, ph, doe, aoe, ack, eoe, burst_end_flag, hit, lref;
  logic [CMD_W-1:0] cmd;
  logic [DQ_W-1:0] din, dout;
  logic [1:0] ub;
  logic bsy;
  logic [CNT_W-1:0] bc;
  logic [ADDR_W-1:0] bp;
  int miscompares = 0;
  int num_checks = 0;
  always #25 clk = ~clk;
  sec_read_port dut_u (.clk(clk), .reset(reset), .command_qualifier(q), .phase_marker(ph),
    .cmd(cmd), .dq_in(din), .dq_out(dout), .dq_oe(doe), .ack_out(ack), .ack_oe(aoe),
    .burst_end_flag_out(burst_end_flag), .burst_end_flag_oe(eoe), .external_memory_upper_bits(ub),
    .last_in_chain_flag(lic), .cascade_tag(tag), .width_cfg(wc), .setup_load(sl),
    .setup_data(sd), .arr_wr(aw), .arr_wr_mask(awm), .arr_addr(aa), .arr_data(ad),
    .search_key(key), .global_mask(gm), .search_addr(8'h02), .search_hit(hit),
    .comparand_idx(4'h5), .comparand_load(cl), .next_free_pointer(8'h20),
    .learn_refused(lref), .busy(bsy), .burst_count(bc), .read_burst_pointer(bp));
  sec_host_model host_u (.clk(clk), .dq_out(dout), .dq_oe(doe), .dq_in(din),
    .command_qualifier(q), .phase_marker(ph), .cmd(cmd));
  ////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [DQ_W-1:0] adr(input logic [4:0] t, input logic [1:0] s,
      input logic [14:0] x);
    return {42'h0, t, s, 4'h0, x};
  endfunction
  task automatic chk_bus(input logic [DQ_W-1:0] got, input logic [DQ_W-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t bus data %h", $time, got);
    end
  endtask
  task automatic chk_st(input logic [4:0] got, input logic [4:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t status %b want %b", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr_arr(input logic m, input logic [7:0] a, input logic [DQ_W-1:0] d);
    aw = 1'b1;
    awm = m;
    aa = a;
    ad = d;
    tick(1);
    aw = 1'b0;
    // one quiet edge so the next call never re-raises the strobe in this step
    tick(1);
  endtask
  // one read walked edge by edge: lead, strobe pairs, close, release
  task automatic rd(input logic [CMD_W-1:0] c, input logic [DQ_W-1:0] a, input int n,
      input logic [DQ_W-1:0] d0, input logic s);
    logic b;
    b = c[2];
    host_u.issue(c, a);
    tick(2);
    chk_st({4'h0, bsy}, 5'h01);
    for (int k = 0; k < n; k++) begin
      chk_st({doe, aoe, ack, eoe, burst_end_flag}, {s, s, 1'b0, s & b, 1'b0});
      tick(1);
      chk_st({doe, aoe, ack, eoe, burst_end_flag}, {s, s, s, s & b, s & b & (k == n - 1)});
      if (s) chk_bus(dout, d0 + DQ_W'(k));
      tick(1);
    end
    chk_st({doe, aoe, ack, eoe, burst_end_flag}, {1'b0, s, 1'b0, s & b, 1'b0});
    tick(1);
    chk_st({doe, aoe, ack, eoe, burst_end_flag}, 5'h00);
  endtask
  task automatic stop_test();
    if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // hang guard, far beyond the roughly 130 cycles the sequence needs
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    stop_test();
  end
  // main sequence
  initial begin
    tick(10);
    reset = 1'b0;
    tick(8);
    chk_st({doe, aoe, ack, eoe, lref}, 5'h00);
    chk_st({4'h0, bsy}, 5'h00);
    for (int i = 2; i < 6; i++) wr_arr(1'b0, 8'(i), BASE + DQ_W'(i));
    wr_arr(1'b1, 8'h02, MSK);
    rd(10'h000, adr(5'h05, SPACE_DATA, 15'h0003), 1, BASE + 68'h3, 1'b1);
    rd(10'h000, adr(5'h05, SPACE_MASK, 15'h0002), 1, MSK, 1'b1);
    rd(10'h000, adr(5'h05, SPACE_REG, 15'h002A), 1, 68'h2A, 1'b1);
    rd(10'h100, adr(5'h05, SPACE_SRAM, 15'h0007), 1, 68'h0, 1'b1);
    chk_st({3'h0, ub}, 5'h02);
    rd(10'h000, adr(5'h07, SPACE_DATA, 15'h0003), 1, 68'h0, 1'b0);
    rd(10'h000, adr(TAG_ALL, SPACE_DATA, 15'h0004), 1, 68'h0, 1'b0);
    lic = 1'b1;
    rd(10'h000, adr(TAG_ALL, SPACE_DATA, 15'h0004), 1, BASE + 68'h4, 1'b1);
    sd = {40'h0, 9'h004, 4'h0, 15'h0002};
    sl = 1'b1;
    tick(1);
    sl = 1'b0;
    rd(10'h004, adr(5'h05, SPACE_DATA, 15'h0000), 4, BASE + 68'h2, 1'b1);
    // pointer moved past the four words, count spent
    chk_bus({44'h0, bc, bp}, {44'h0, 9'h000, 15'h0006});
    key = BASE ^ 68'hF0F0;
    cl = 1'b1;
    tick(1);
    cl = 1'b0;
    host_u.issue(10'h017, 68'h0);
    tick(6);
    rd(10'h000, adr(5'h05, SPACE_DATA, 15'h0020), 1, BASE ^ 68'hF0F0, 1'b1);
    wc = SEC_W272;
    host_u.issue(10'h017, 68'h0);
    // the flag from the b cycle already stands when the task returns
    seen = lref;
    repeat (6) begin
      tick(1);
      seen = seen | lref;
    end
    chk_st({4'h0, seen}, 5'h01);
    wc = SEC_W68;
    // exact, local mask, plain miss, global mask
    for (int i = 0; i < 4; i++) begin
      key = BASE + 68'h2 ^ flip[i];
      gm = ~gclr[i];
      tick(2);
      chk_st({4'h0, hit}, {4'h0, hv[i]});
    end
    stop_test();
  end
endmodule
bind sec_read_port sec_rp_props props_u (.clk(clk), .reset(reset),
  .command_qualifier(command_qualifier), .cmd(cmd), .dq_in(dq_in),
  .last_in_chain_flag(last_in_chain_flag), .cascade_tag(cascade_tag),
  .width_cfg(width_cfg), .dq_oe(dq_oe), .ack_out(ack_out), .ack_oe(ack_oe),
  .burst_end_flag_out(burst_end_flag_out), .burst_end_flag_oe(burst_end_flag_oe),
  .external_memory_upper_bits(external_memory_upper_bits), .learn_refused(learn_refused));
`default_nettype wire
